// ==== core/scc_cal_ctrl.sv ====
// scc_cal_ctrl: sysref calibration registers and the calibration engine that
// derives the sampling-clock delay from sysref edges and a phase detector.
// assumes: register port strobes are synchronous to i_sys_clk; i_sysref and
// i_phase_early are asynchronous pins; i_manual_delay comes from the manual delay register.
`default_nettype none
module scc_cal_ctrl import scc_pkg::*; #(
	parameter int unsigned CAL_BUDGET_UNIT = BUDGET_UNIT
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [23:0] o_reg_rdata,
	input wire logic i_sysref,
	input wire logic i_phase_early,
	input wire logic [DELAY_W-1:0] i_manual_delay,
	output logic [DELAY_W-1:0] o_sampling_clock_delay,
	output logic o_cal_complete_flag,
	output logic o_digital_rail_noise_suppress_en,
	output logic o_clock_rail_noise_suppress_en
);
	typedef struct packed {
		scc_state_e st;
		logic [7:0] enable_reg;
		logic [7:0] config_reg;
		logic [7:0] noise_reg;
		logic done;
		logic [DELAY_W-1:0] delay;
		logic [DELAY_W-1:0] out_delay;
		logic [23:0] rdata;
		logic sysref_q;
		logic [15:0] per_cnt;
		logic [8:0] acc_cnt;
		logic [8:0] avg_cnt;
		logic [16:0] hit_sum;
		logic [31:0] wd_cnt;
	} scc_state_s;

	scc_state_s r;
	scc_state_s next_r;
	logic [1:0] sync_out;
	logic sysref_s;
	logic early_s;
	logic [1:0] avg_code;
	logic [1:0] acc_code;
	logic [8:0] acc_last;
	logic [8:0] avg_last;
	logic [4:0] sum_shift;
	logic [31:0] budget;
	logic [15:0] max_period;
	logic sysref_edge;
	logic wr_enable;
	logic start;
	logic stop;
	logic [16:0] sum_now;
	logic [24:0] scaled;
	logic [7:0] fine;

	// both pins cross into the sampling-clock domain before use
	scc_sync2 #(.W(2)) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_phase_early, i_sysref}),
		.o_sync(sync_out)
	);
	assign sysref_s = sync_out[0];
	assign early_s = sync_out[1];

	// configuration decode
	assign avg_code = r.config_reg[AVG_LSB+1:AVG_LSB];
	assign acc_code = r.config_reg[ACC_LSB+1:ACC_LSB];
	assign acc_last = 9'((9'h004 << {acc_code, 1'b0}) - 9'h001);
	assign avg_last = 9'((9'h004 << {avg_code, 1'b0}) - 9'h001);
	assign sum_shift = 5'({3'h0, avg_code} + {3'h0, acc_code} + 5'h02) << 1;
	assign budget = 32'(CAL_BUDGET_UNIT) << sum_shift;

	// longest period the selected accumulation length can follow
	always_comb begin
		case (acc_code)
			2'h0: max_period = MAX_PERIOD_0;
			2'h1: max_period = MAX_PERIOD_1;
			2'h2: max_period = MAX_PERIOD_2;
			default: max_period = MAX_PERIOD_3;
		endcase
	end

	// edge detect reads only the stable synchroniser stage
	assign sysref_edge = sysref_s & ~r.sysref_q;
	assign wr_enable = i_reg_wr && (i_reg_addr == ADDR_ENABLE);
	assign start = wr_enable && i_reg_wdata[ENABLE_BIT] && !r.enable_reg[ENABLE_BIT];
	assign stop = wr_enable && !i_reg_wdata[ENABLE_BIT];

	// result scaling: fraction of early decisions mapped onto 256 fine steps
	assign sum_now = r.hit_sum + {16'h0000, early_s};
	assign scaled = 25'({sum_now, 8'h00} >> sum_shift);
	assign fine = (scaled > 25'h00000FF) ? 8'hFF : scaled[7:0];

	// register file, engine and output path
	always_comb begin
		next_r = r;
		next_r.sysref_q = sysref_s;
		if (i_reg_wr) begin
			case (i_reg_addr)
				ADDR_ENABLE: next_r.enable_reg = i_reg_wdata;
				ADDR_CONFIG: next_r.config_reg = i_reg_wdata;
				ADDR_NOISE: next_r.noise_reg = i_reg_wdata;
				default: ; // result register and unmapped offsets ignore writes
			endcase
		end
		if (i_reg_rd) begin
			case (i_reg_addr)
				ADDR_ENABLE: next_r.rdata = {16'h0000, r.enable_reg};
				ADDR_CONFIG: next_r.rdata = {16'h0000, r.config_reg};
				ADDR_NOISE: next_r.rdata = {16'h0000, r.noise_reg};
				ADDR_RESULT: next_r.rdata = {6'h00, r.done, r.delay};
				default: next_r.rdata = 24'h000000;
			endcase
		end
		// active states are guarded by the run-time budget
		if (r.st == ST_WAIT_EDGE || r.st == ST_MEASURE || r.st == ST_ACCUM) begin
			next_r.wd_cnt = r.wd_cnt + 32'h00000001;
		end
		case (r.st)
			ST_WAIT_EDGE: begin
				if (sysref_edge) begin
					next_r.st = ST_MEASURE;
					next_r.per_cnt = 16'h0001;
				end
			end
			ST_MEASURE: begin
				if (r.per_cnt > max_period) begin
					next_r.st = ST_FAIL;
				end else if (sysref_edge) begin
					next_r.st = ST_ACCUM;
					next_r.acc_cnt = 9'h000;
				end else begin
					next_r.per_cnt = r.per_cnt + 16'h0001;
				end
			end
			ST_ACCUM: begin
				next_r.hit_sum = sum_now;
				next_r.acc_cnt = r.acc_cnt + 9'h001;
				if (r.acc_cnt == acc_last) begin
					next_r.avg_cnt = r.avg_cnt + 9'h001;
					if (r.avg_cnt == avg_last) begin
						// coarse holds the early count above the fine range
						next_r.delay = {fine[7], scaled[15:8], fine};
						next_r.done = 1'b1;
						next_r.st = ST_DONE;
					end else begin
						next_r.st = ST_WAIT_EDGE;
					end
				end
			end
			ST_IDLE, ST_DONE, ST_FAIL: ;
			default: next_r.st = ST_IDLE;
		endcase
		if ((r.st != ST_IDLE) && (r.st != ST_DONE) && (r.st != ST_FAIL) && (r.wd_cnt >= budget)) begin
			next_r.st = ST_FAIL;
		end
		// a new start or a disable always clears the done flag; the old delay is kept
		if (start) begin
			next_r.st = ST_WAIT_EDGE;
			next_r.done = 1'b0;
			next_r.hit_sum = 17'h00000;
			next_r.avg_cnt = 9'h000;
			next_r.acc_cnt = 9'h000;
			next_r.per_cnt = 16'h0000;
			next_r.wd_cnt = 32'h00000000;
		end else if (stop) begin
			next_r.st = ST_IDLE;
			next_r.done = 1'b0;
		end
		// delay mux registered so the output never glitches
		next_r.out_delay = r.enable_reg[ENABLE_BIT] ? r.delay : i_manual_delay;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.enable_reg <= ENABLE_RESET;
			r.config_reg <= CONFIG_RESET;
			r.noise_reg <= NOISE_RESET;
			r.delay <= DELAY_RESET;
		end else begin
			r <= next_r;
		end
	end

	assign o_reg_rdata = r.rdata;
	assign o_sampling_clock_delay = r.out_delay;
	assign o_cal_complete_flag = r.done;
	assign o_digital_rail_noise_suppress_en = r.noise_reg[DIG_NOISE_BIT];
	assign o_clock_rail_noise_suppress_en = r.noise_reg[CLK_NOISE_BIT];

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_enable_rise;
		$rose(r.enable_reg[ENABLE_BIT]);
	endsequence
	sequence s_leave_idle;
		(r.st == ST_IDLE) ##1 (r.st == ST_WAIT_EDGE);
	endsequence

	property p_manual_path;
		!r.enable_reg[ENABLE_BIT] |=> (o_sampling_clock_delay == $past(i_manual_delay));
	endproperty
	a_manual_path: assert property (p_manual_path) else $error("manual delay not passed");

	property p_cal_path;
		(r.enable_reg[ENABLE_BIT] && r.done) |=> (o_sampling_clock_delay == $past(r.delay));
	endproperty
	a_cal_path: assert property (p_cal_path) else $error("calibrated delay not used");

	property p_start_on_rise;
		s_enable_rise |-> (r.st == ST_WAIT_EDGE) && !r.done;
	endproperty
	a_start_on_rise: assert property (p_start_on_rise) else $error("rise did not start run");

	property p_only_rise_starts;
		s_leave_idle |-> $rose(r.enable_reg[ENABLE_BIT]);
	endproperty
	a_only_rise_starts: assert property (p_only_rise_starts) else $error("run started without rise");

	property p_period_fail;
		(r.st == ST_MEASURE && r.per_cnt > max_period && !i_reg_wr) |=> (r.st == ST_FAIL);
	endproperty
	a_period_fail: assert property (p_period_fail) else $error("long period did not fail");

	property p_budget;
		(r.st == ST_WAIT_EDGE || r.st == ST_MEASURE || r.st == ST_ACCUM) |-> (r.wd_cnt <= budget);
	endproperty
	a_budget: assert property (p_budget) else $error("calibration exceeded budget");

	property p_done_needs_enable;
		r.done |-> r.enable_reg[ENABLE_BIT] && (r.st == ST_DONE);
	endproperty
	a_done_needs_enable: assert property (p_done_needs_enable) else $error("flag without enable");

	property p_noise_write;
		(i_reg_wr && i_reg_addr == ADDR_NOISE) |=> (o_digital_rail_noise_suppress_en == $past(i_reg_wdata[DIG_NOISE_BIT]))
			&& (o_clock_rail_noise_suppress_en == $past(i_reg_wdata[CLK_NOISE_BIT]));
	endproperty
	a_noise_write: assert property (p_noise_write) else $error("noise bits not applied");

	property p_result_readonly;
		(i_reg_wr && i_reg_addr == ADDR_RESULT && r.st != ST_ACCUM) |=> $stable(r.delay);
	endproperty
	a_result_readonly: assert property (p_result_readonly) else $error("result register written");
endmodule : scc_cal_ctrl
`default_nettype wire

// ==== core/scc_pkg.sv ====
// scc_pkg: register map, field positions, reset values and calibration constants
// for the sysref calibration control block.
// assumes: a single sampling-clock domain and an 8-bit write / 24-bit read register port.
`default_nettype none
package scc_pkg;
	// register offsets on the configuration port
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] ADDR_NOISE = 12'h2A2;
	localparam logic [ADDR_W-1:0] ADDR_ENABLE = 12'h2B0;
	localparam logic [ADDR_W-1:0] ADDR_CONFIG = 12'h2B1;
	localparam logic [ADDR_W-1:0] ADDR_RESULT = 12'h2B2;

	// reset values
	localparam logic [7:0] ENABLE_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h05;
	localparam logic [7:0] NOISE_RESET = 8'h00;
	localparam logic [16:0] DELAY_RESET = 17'h00000;

	// field positions
	localparam int ENABLE_BIT = 0;
	localparam int AVG_LSB = 2;
	localparam int ACC_LSB = 0;
	localparam int DIG_NOISE_BIT = 5;
	localparam int CLK_NOISE_BIT = 4;
	localparam int DONE_BIT = 17;
	localparam int DELAY_W = 17;
	localparam int INV_BIT = 16;
	localparam int COARSE_LSB = 8;

	// longest sysref period accepted per accumulation-length code, in sampling-clock cycles
	localparam logic [15:0] MAX_PERIOD_0 = 16'h0080;
	localparam logic [15:0] MAX_PERIOD_1 = 16'h0680;
	localparam logic [15:0] MAX_PERIOD_2 = 16'h1E80;
	localparam logic [15:0] MAX_PERIOD_3 = 16'h7E80;

	// run-time bound: unit times four to the power (avg + acc + 2)
	localparam int BUDGET_MULT_A = 384;
	localparam int BUDGET_MULT_B = 19;
	localparam int unsigned BUDGET_UNIT = BUDGET_MULT_A * BUDGET_MULT_B;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WAIT_EDGE,
		ST_MEASURE,
		ST_ACCUM,
		ST_DONE,
		ST_FAIL
	} scc_state_e;
endpackage : scc_pkg
`default_nettype wire

// ==== core/scc_sync2.sv ====
// scc_sync2: two-flop synchroniser for a bundle of independent level inputs.
// assumes: each bit is a slow level or pulse wider than two clock cycles.
`default_nettype none
module scc_sync2 #(
	parameter int W = 1
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} scc_sync_s;

	scc_sync_s r;
	scc_sync_s next_r;

	// meta feeds only the second stage
	always_comb begin
		next_r.meta = i_async;
		next_r.stable = r.meta;
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_sync = r.stable;
endmodule : scc_sync2
`default_nettype wire

// ==== testbench/sysref_calibration_control_tb.sv ====
// sysref_calibration_control_tb: directed tests of register port, calibration runs and noise bits.
// assumes: scc_pkg and scc_cal_ctrl compiled first; one 100 MHz clock, bench drives every input.
`default_nettype none
module sysref_calibration_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import scc_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic [23:0] rdata;
	logic sysref = 1'b0;
	logic early = 1'b0;
	logic [DELAY_W-1:0] manual = 17'h1A5C3;
	logic [DELAY_W-1:0] delay;
	logic flag;
	logic dig_ns;
	logic clk_ns;
	int errors = 0;
	int checks_done = 0;
	int per = 40;
	int cnt = 0;
	logic [23:0] v;
	logic [16:0] saved;
	int n;

	always #5 i_sys_clk = ~i_sys_clk;

	// sysref pulse four cycles wide so the two-flop synchroniser cannot miss it
	always @(posedge i_sys_clk) begin
		cnt <= (cnt + 1 >= per) ? 0 : cnt + 1;
		sysref <= (cnt < 4);
	end

	scc_cal_ctrl scc_cal_ctrl_i (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_reg_addr(addr),
		.i_reg_wr(wr),
		.i_reg_wdata(wdata),
		.i_reg_rd(rd),
		.o_reg_rdata(rdata),
		.i_sysref(sysref),
		.i_phase_early(early),
		.i_manual_delay(manual),
		.o_sampling_clock_delay(delay),
		.o_cal_complete_flag(flag),
		.o_digital_rail_noise_suppress_en(dig_ns),
		.o_clock_rail_noise_suppress_en(clk_ns)
	);

	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one strobe cycle; the write lands at the edge that follows
	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_sys_clk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [ADDR_W-1:0] a, output logic [23:0] d);
		@(posedge i_sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_sys_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rreg

	task automatic t_reset();
		rreg(ADDR_ENABLE, v);
		chk("enable", 24'h000000, v);
		rreg(ADDR_CONFIG, v);
		chk("config", 24'h000005, v);
		rreg(ADDR_NOISE, v);
		chk("noise", 24'h000000, v);
		rreg(12'h000, v);
		chk("unmapped", 24'h000000, v);
		chk("delay", {7'h00, manual}, {7'h00, delay});
		chk("flag", 24'h000000, {23'h0, flag});
		$display("test reset done");
	endtask : t_reset

	task automatic t_noise();
		wreg(ADDR_NOISE, 8'h30);
		#1;
		chk("dig_ns", 24'h1, {23'h0, dig_ns});
		chk("clk_ns", 24'h1, {23'h0, clk_ns});
		wreg(ADDR_NOISE, 8'h10);
		#1;
		chk("dig_ns", 24'h0, {23'h0, dig_ns});
		chk("clk_ns", 24'h1, {23'h0, clk_ns});
		rreg(ADDR_NOISE, v);
		chk("noise", 24'h000010, v);
		$display("test noise done");
	endtask : t_noise

	// every averaging and accumulation code, ending at the shortest setting
	task automatic t_config();
		for (int c = 3; c >= 0; c--) begin
			wreg(ADDR_CONFIG, 8'(c * 5));
			rreg(ADDR_CONFIG, v);
			chk("config", 24'(c * 5), v);
		end
		$display("test config done");
	endtask : t_config

	task automatic t_cal();
		per = 40;
		@(posedge i_sys_clk);
		early <= 1'b1;
		wreg(ADDR_CONFIG, 8'h00);
		// no converter calibration runs in this bench, so enable may be set now
		wreg(ADDR_ENABLE, 8'h01);
		#1;
		chk("flag", 24'h0, {23'h0, flag});
		// full budget is far longer; this run is a few hundred cycles
		// look past the edge so the flag launched there is settled
		for (n = 0; n < 3000 && flag !== 1'b1; n++) begin
			@(posedge i_sys_clk);
			#1;
		end
		chk("finished", 24'h1, {23'h0, n < 3000});
		repeat (2) @(posedge i_sys_clk);
		rreg(ADDR_RESULT, v);
		chk("done_bit", 24'h1, {23'h0, v[DONE_BIT]});
		// every sample early: fine saturates at FF, coarse 01, invert follows fine msb
		chk("delay_val", {7'h00, 17'h101FF}, {7'h00, v[16:0]});
		chk("delay", {7'h00, 17'h101FF}, {7'h00, delay});
		saved = v[16:0];
		wreg(ADDR_RESULT, 8'h00);
		rreg(ADDR_RESULT, v);
		chk("result", {6'h00, 1'b1, saved}, v);
		wreg(ADDR_ENABLE, 8'h01);
		repeat (100) @(posedge i_sys_clk);
		#1;
		chk("flag", 24'h1, {23'h0, flag});
		wreg(ADDR_ENABLE, 8'h00);
		repeat (2) @(posedge i_sys_clk);
		#1;
		chk("flag", 24'h0, {23'h0, flag});
		chk("delay", {7'h00, manual}, {7'h00, delay});
		$display("test calibration done");
	endtask : t_cal

	// period 200 exceeds the 128 allowed at accumulation code 0
	task automatic t_fail();
		per = 200;
		wreg(ADDR_ENABLE, 8'h01);
		repeat (2000) @(posedge i_sys_clk);
		#1;
		chk("flag", 24'h0, {23'h0, flag});
		rreg(ADDR_RESULT, v);
		chk("done_bit", 24'h0, {23'h0, v[DONE_BIT]});
		chk("delay", {7'h00, saved}, {7'h00, delay});
		wreg(ADDR_ENABLE, 8'h00);
		$display("test period fail done");
	endtask : t_fail

	// 16 averages of 16 cycles, no early decisions; then manual path follows a new value
	task automatic t_cal_avg();
		per = 40;
		@(posedge i_sys_clk);
		early <= 1'b0;
		wreg(ADDR_CONFIG, 8'h05);
		wreg(ADDR_ENABLE, 8'h01);
		for (n = 0; n < 4000 && flag !== 1'b1; n++) begin
			@(posedge i_sys_clk);
			#1;
		end
		chk("finished", 24'h1, {23'h0, n < 4000});
		// each average spans two sysref periods, so 16 of them cannot end inside 640 cycles
		chk("slow_run", 24'h1, {23'h0, n > 640});
		rreg(ADDR_RESULT, v);
		chk("result", 24'h020000, v);
		chk("delay", 24'h000000, {7'h00, delay});
		wreg(ADDR_ENABLE, 8'h00);
		manual <= 17'h0F00F;
		repeat (2) @(posedge i_sys_clk);
		#1;
		chk("flag", 24'h0, {23'h0, flag});
		chk("delay", 24'h00F00F, {7'h00, delay});
		$display("test averaged calibration done");
	endtask : t_cal_avg

	task automatic print_verdict();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// all tests take well under 10000 cycles
	initial begin
		#200us;
		errors++;
		print_verdict();
	end

	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		t_reset();
		t_noise();
		t_config();
		t_cal();
		t_fail();
		t_cal_avg();
		print_verdict();
	end
endmodule : sysref_calibration_control_tb
`default_nettype wire
